// ==== hdl/monitor_relay_pkg.sv ====
// Package for the stacked monitor result formatter and stack relay.
// Assumes one 100 MHz clock; all pins arrive asynchronously.
package monitor_relay_pkg;

  // Converter result format
  localparam int RESULT_BITS = 14;
  localparam logic [13:0] RESULT_FULL = 14'h3fff;
  localparam int NUM_CHANNELS = 9;
  localparam int NUM_CELLS = 6;
  localparam logic [3:0] CH_TEMP1 = 4'h6;
  localparam logic [3:0] CH_AUX = 4'h8;

  // Register offsets
  localparam logic [6:0] AUX_RESULT_HIGH = 7'h01;
  localparam logic [6:0] CELL_ONE_RESULT_HIGH = 7'h03;
  localparam logic [6:0] CELL_ONE_RESULT_LOW = 7'h04;
  localparam logic [6:0] LAST_RESULT_LOW = 7'h12;
  localparam logic [6:0] CONVERSION_CONTROL = 7'h30;
  localparam logic [6:0] CONVERSION_STATUS = 7'h31;

  // Conversion control fields and reset values
  localparam int CTRL_COUNT_MSB = 2;
  localparam int CTRL_AUX_SRC = 3;
  localparam int CTRL_START = 4;
  localparam logic [2:0] CELL_COUNT_RESET = 3'h6;
  localparam logic AUX_SRC_RESET = 1'b0;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_REQ = 3'b010,
    SEQ_WAIT = 3'b100
  } seq_t;

  // One stack port's inbound signals
  typedef struct packed {
    logic sclk;
    logic csN;
    logic dataIn;
    logic convStart;
  } port_in_t;

  // Signals arriving from the upper device
  typedef struct packed {
    logic dataReturn;
    logic ready;
    logic fault;
    logic alert;
  } upper_in_t;

  // One downward port's outbound signals
  typedef struct packed {
    logic dataOut;
    logic dataOe;
    logic ready;
    logic fault;
    logic alert;
  } port_out_t;

  // Pin bundle that is synchronised as one vector
  typedef struct packed {
    logic hostSelect;
    port_in_t host;
    port_in_t lower;
    upper_in_t upper;
  } pins_t;

  // Whole module state
  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    logic sclkPrev;
    logic convPrev;
    logic [2:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic firstByte;
    logic loadPending;
    logic isWrite;
    logic driving;
    logic [6:0] addr;
    logic [2:0] cellCount;
    logic auxSource;
    logic startReq;
    seq_t seq;
    logic [3:0] channel;
    logic [NUM_CHANNELS-1:0][RESULT_BITS-1:0] results;
    port_in_t upOut;
    port_out_t hostOut;
    port_out_t lowerOut;
  } state_t;

endpackage

// ==== hdl/stacked_monitor_adc_result_relay.sv ====
// Result formatter, conversion sequencer, register port and stack relay.
// Assumes the converter core answers on clk; all pins are asynchronous.
//
// Behaviour
// - Results are 14-bit unsigned magnitudes; the top two word bits read zero.
// - Each word spans two byte registers, high byte at the lower address.
// - First cell result reads at 0x03 (high) and 0x04 (low).
// - Offset-corrected results clamp at zero or full scale, never wrap.
// - Mux selects nine sources: six cells, two temperatures, one auxiliary.
// - Auxiliary channel switches between aux input pair and module supply.
// - Cell count field limits the scan to connected cells.
// - Host select low: host-port clock, select, data, start go upward.
// - Host select high: lower-port clock, select, data, start go upward.
// - Host select low: upper return data goes to host-port data out.
// - Host select high: upper return data goes to lower-port data out.
// - Upper ready, fault and alert go down the selected port.
// - Chip select low frames a packet around all clock edges.
// - Host-port data out is driven only while chip select is low.
`timescale 1ns/100ps
module stacked_monitor_adc_result_relay
  import monitor_relay_pkg::*;
#(
  parameter int OFFSET_WIDTH = 8
) (
  input wire logic clk, // 100 MHz
  input wire logic rst, // Synchronous, active high
  input wire logic hostSelect, // 1: lower port feeds the relay
  input wire port_in_t hostIn, // Host-port inputs
  input wire port_in_t lowerIn, // Lower-device-port inputs
  input wire upper_in_t upperIn, // Returns from the upper device
  input wire logic localFault, // Own protection fault
  input wire logic localAlert, // Own alert condition
  input wire logic convDone, // Converter result strobe
  input wire logic [RESULT_BITS-1:0] convRaw, // Raw converter word
  input wire logic signed [OFFSET_WIDTH-1:0] convOffset, // Trim offset
  output port_in_t upOut, // Toward the upper device
  output port_out_t hostOut, // Host-port outputs
  output port_out_t lowerOut, // Lower-device-port outputs
  output logic convReq, // Start one sample
  output logic [3:0] convChannel, // Mux source index
  output logic auxSource // 1: module supply on aux channel
);

  // Offset must leave room for a real result
  if (OFFSET_WIDTH < 2 || OFFSET_WIDTH > RESULT_BITS) begin : g_check
    $error("OFFSET_WIDTH out of range");
  end

  state_t q;
  state_t d;

  // Raw plus trim, clamped rather than wrapped
  function automatic logic [RESULT_BITS-1:0] saturate(
    input logic [RESULT_BITS-1:0] raw,
    input logic signed [OFFSET_WIDTH-1:0] off
  );
    logic signed [RESULT_BITS+1:0] sum;
    sum = $signed({2'b00, raw}) + (RESULT_BITS+2)'(off);
    if (sum < 0) begin
      saturate = '0;
    end else if (sum > $signed({2'b00, RESULT_FULL})) begin
      saturate = RESULT_FULL;
    end else begin
      saturate = sum[RESULT_BITS-1:0];
    end
  endfunction

  // Last cell index scanned; out-of-range counts scan all cells
  function automatic logic [3:0] lastCell(input logic [2:0] count);
    if (count == 3'h0 || count > 3'h6) begin
      lastCell = 4'h5;
    end else begin
      lastCell = {1'b0, count} - 4'h1;
    end
  endfunction

  // Register read decode
  function automatic logic [7:0] regRead(input logic [6:0] a, input state_t s);
    logic [15:0] word;
    logic [6:0] k;
    word = '0;
    k = a - CELL_ONE_RESULT_HIGH;
    regRead = '0;
    if (a == AUX_RESULT_HIGH || a == AUX_RESULT_HIGH + 7'h1) begin
      word = {2'b00, s.results[CH_AUX]};
      regRead = a[0] ? word[15:8] : word[7:0];
    end else if (a >= CELL_ONE_RESULT_HIGH && a <= LAST_RESULT_LOW) begin
      word = {2'b00, s.results[k[4:1]]};
      regRead = k[0] ? word[7:0] : word[15:8];
    end else if (a == CONVERSION_CONTROL) begin
      regRead = {3'h0, s.startReq, s.auxSource, s.cellCount};
    end else if (a == CONVERSION_STATUS) begin
      regRead = {3'h0, s.channel, s.seq != SEQ_IDLE};
    end
  endfunction

  // Next-state logic
  always_comb begin
    port_in_t sel;
    logic rise;
    logic fall;
    logic [7:0] byteIn;
    logic [3:0] ch;
    logic startSet;
    d = q;
    startSet = 1'b0;
    d.sync1 = {hostSelect, hostIn, lowerIn, upperIn};
    d.sync2 = q.sync1;
    sel = q.sync2.hostSelect ? q.sync2.lower : q.sync2.host;
    ch = q.channel;
    byteIn = {q.shiftIn[6:0], sel.dataIn};
    rise = sel.sclk && !q.sclkPrev;
    fall = !sel.sclk && q.sclkPrev;
    d.sclkPrev = sel.sclk;
    d.convPrev = sel.convStart;

    // Serial register port, mode 0, framed by chip select
    if (sel.csN) begin
      d.bitCnt = '0;
      d.firstByte = 1'b1;
      d.driving = 1'b0;
      d.loadPending = 1'b0;
    end else if (rise) begin
      d.shiftIn = byteIn;
      d.bitCnt = q.bitCnt + 3'h1;
      if (q.bitCnt == 3'h7) begin
        d.loadPending = 1'b1;
        if (q.firstByte) begin
          d.firstByte = 1'b0;
          d.addr = byteIn[7:1];
          d.isWrite = byteIn[0];
          d.driving = !byteIn[0];
        end else begin
          d.addr = q.addr + 7'h1;
          if (q.isWrite && q.addr == CONVERSION_CONTROL) begin
            d.cellCount = byteIn[CTRL_COUNT_MSB:0];
            d.auxSource = byteIn[CTRL_AUX_SRC];
            startSet = byteIn[CTRL_START];
          end
        end
      end
    end else if (fall) begin
      d.shiftOut = q.loadPending ? regRead(q.addr, q) : {q.shiftOut[6:0], 1'b0};
      d.loadPending = 1'b0;
    end

    // Start from the selected pin edge or the control bit
    if (sel.convStart && !q.convPrev) begin
      startSet = 1'b1;
    end

    // Scan sequencer
    case (q.seq)
      SEQ_IDLE: begin
        if (q.startReq) begin
          d.channel = '0;
          d.seq = SEQ_REQ;
        end
      end
      SEQ_REQ: begin
        d.seq = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (convDone) begin
          d.results[ch] = saturate(convRaw, convOffset);
          d.seq = SEQ_REQ;
          if (ch == lastCell(q.cellCount)) begin
            d.channel = CH_TEMP1;
          end else if (ch == CH_AUX) begin
            d.seq = SEQ_IDLE;
            d.startReq = 1'b0; // Self-clears when the scan ends
          end else begin
            d.channel = ch + 4'h1;
          end
        end
      end
      default: begin
        d.seq = SEQ_IDLE;
      end
    endcase

    // A start in the clearing cycle wins, so no request is lost
    if (startSet) begin
      d.startReq = 1'b1;
    end

    // Relay up the stack
    d.upOut = sel;

    // Relay down the stack; own data overrides the upper return
    d.hostOut = '0;
    d.lowerOut = '0;
    if (q.sync2.hostSelect) begin
      d.lowerOut.dataOut = q.driving ? q.shiftOut[7] : q.sync2.upper.dataReturn;
      d.lowerOut.dataOe = !sel.csN;
      d.lowerOut.ready = q.sync2.upper.ready;
      d.lowerOut.fault = q.sync2.upper.fault | localFault;
      d.lowerOut.alert = q.sync2.upper.alert | localAlert;
    end else begin
      d.hostOut.dataOut = q.driving ? q.shiftOut[7] : q.sync2.upper.dataReturn;
      d.hostOut.dataOe = !sel.csN;
      d.hostOut.ready = q.sync2.upper.ready;
      d.hostOut.fault = q.sync2.upper.fault | localFault;
      d.hostOut.alert = q.sync2.upper.alert | localAlert;
    end
  end

  // State register; results keep reset at zero so reads are defined
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.seq <= SEQ_IDLE;
      q.firstByte <= 1'b1;
      q.cellCount <= CELL_COUNT_RESET;
      q.auxSource <= AUX_SRC_RESET;
      q.sync1.host.csN <= 1'b1;
      q.sync2.host.csN <= 1'b1;
      q.sync1.lower.csN <= 1'b1;
      q.sync2.lower.csN <= 1'b1;
      q.upOut.csN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign upOut = q.upOut;
  assign hostOut = q.hostOut;
  assign lowerOut = q.lowerOut;
  assign convReq = (q.seq == SEQ_REQ);
  assign convChannel = q.channel;
  assign auxSource = q.auxSource;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sampleTaken;
    q.seq == SEQ_WAIT && convDone;
  endsequence

  sequence s_lastCellTaken;
    s_sampleTaken ##0 q.channel == lastCell(q.cellCount);
  endsequence

  a_cell_one_map: assert property (
    s_sampleTaken ##0 q.channel == 4'h0 |=>
      regRead(CELL_ONE_RESULT_HIGH, q) == {2'b00, q.results[0][13:8]} &&
      regRead(CELL_ONE_RESULT_LOW, q) == q.results[0][7:0])
    else $error("cell one registers mismatch");

  a_high_zero: assert property (
    s_sampleTaken |=> (regRead(CELL_ONE_RESULT_HIGH, q) & 8'hc0) == 8'h00)
    else $error("result top bits not zero");

  a_clamp_low: assert property (
    s_sampleTaken ##0 ($signed({2'b00, convRaw}) + (RESULT_BITS+2)'(convOffset) < 0) |=>
      q.results[$past(q.channel)] == '0)
    else $error("result wrapped below zero");

  a_clamp_high: assert property (
    s_sampleTaken ##0 ($signed({2'b00, convRaw}) + (RESULT_BITS+2)'(convOffset) >
      $signed({2'b00, RESULT_FULL})) |=>
      q.results[$past(q.channel)] == RESULT_FULL)
    else $error("result wrapped above full scale");

  a_channel_range: assert property (
    convReq |-> convChannel < 4'(NUM_CHANNELS) ##1 q.seq == SEQ_WAIT)
    else $error("illegal mux source");

  a_cell_count: assert property (
    s_lastCellTaken |=> q.channel == CH_TEMP1 && convReq)
    else $error("scan passed last connected cell");

  a_relay_up: assert property (
    !q.sync2.hostSelect |=> upOut == $past(q.sync2.host))
    else $error("host port not relayed upward");

  a_relay_lower: assert property (
    q.sync2.hostSelect |=> upOut == $past(q.sync2.lower) && !hostOut.dataOe)
    else $error("lower port not relayed upward");

  a_return_host: assert property (
    !q.sync2.hostSelect && !q.driving |=>
      hostOut.dataOut == $past(q.sync2.upper.dataReturn))
    else $error("upper data not returned to host port");

  a_return_lower: assert property (
    q.sync2.hostSelect && !q.driving |=>
      lowerOut.dataOut == $past(q.sync2.upper.dataReturn) && !hostOut.fault)
    else $error("upper data not returned to lower port");

  a_fault_merge: assert property (
    !q.sync2.hostSelect && (q.sync2.upper.fault || localFault) |=> hostOut.fault)
    else $error("fault not merged downward");

  a_release: assert property (
    !q.sync2.hostSelect && q.sync2.host.csN |=> !hostOut.dataOe)
    else $error("host data driven with select high");

endmodule

// ==== bench/host_master.sv ====
// Host stand-in driving the host-port pins as a serial master.
// Assumes the device bundles its data pin as dataOut plus dataOe.
`timescale 1ns/100ps
module host_master
  import monitor_relay_pkg::*;
(
  input wire port_out_t hostOut, // Device host-port outputs
  output port_in_t pins // Host-port pins
);
  logic line;

  // Released data line floats up through an assumed pull-up
  assign line = hostOut.dataOe ? hostOut.dataOut : 1'b1;

  initial pins = port_in_t'(4'h4);

  // Gap first, so back-to-back packets never crowd the device
  task automatic frame_open();
    #3000;
    pins.csN = 1'b0;
    #80;
  endtask

  task automatic frame_close();
    #80;
    pins.csN = 1'b1;
  endtask

  // One byte, MSB first, 160 ns clock; read data taken before each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.dataIn = tx[i];
      #80;
      rx[i] = line;
      pins.sclk = 1'b1;
      #80;
      pins.sclk = 1'b0;
    end
  endtask

  task automatic pulse_conv();
    pins.convStart = 1'b1;
    #1000;
    pins.convStart = 1'b0;
  endtask
endmodule

// ==== bench/stacked_monitor_adc_result_relay_tb.sv ====
// Self-checking bench: scans, register reads and stack relay.
// Assumes host_master drives the host port; converter is modelled here.
`timescale 1ns/100ps
module stacked_monitor_adc_result_relay_tb;
  import monitor_relay_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hostSelect = 1'b0;
  port_in_t hostIn;
  port_in_t lowerIn = port_in_t'(4'h4);
  upper_in_t upperIn = '0;
  logic localFault = 1'b0;
  logic localAlert = 1'b0;
  logic convDone = 1'b0;
  logic [13:0] convRaw = '0;
  logic signed [7:0] convOffset = '0;
  port_in_t upOut;
  port_out_t hostOut, lowerOut, want;
  logic convReq, auxSource;
  logic [3:0] convChannel;
  logic [7:0] rx;
  int err_count = 0;
  int compares = 0;
  int seed = 22;
  int chq[$];
  int expRes[9];
  int lat, v, ch;

  always #5 clk = ~clk;

  stacked_monitor_adc_result_relay uut (.clk(clk), .rst(rst), .hostSelect(hostSelect),
    .hostIn(hostIn), .lowerIn(lowerIn), .upperIn(upperIn), .localFault(localFault),
    .localAlert(localAlert), .convDone(convDone), .convRaw(convRaw),
    .convOffset(convOffset), .upOut(upOut), .hostOut(hostOut), .lowerOut(lowerOut),
    .convReq(convReq), .convChannel(convChannel), .auxSource(auxSource));

  host_master host (.hostOut(hostOut), .pins(hostIn));

  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_pins(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_mv(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask

  // Converter stand-in; raw values lean on both clamp edges
  always begin
    @(posedge clk iff convReq === 1'b1);
    ch = convChannel;
    if (chq.size() > 0) check_pins("channel", 8'(chq.pop_front()), {4'h0, convChannel});
    lat = 1 + $unsigned($random(seed)) % 8;
    repeat (lat) @(negedge clk);
    v = $random(seed);
    convRaw = v[1] ? 14'(v >> 2) : (v[0] ? 14'h3ffe : 14'h0002);
    convOffset = 8'(v >> 16);
    convDone = 1'b1;
    v = int'(convRaw) + int'(convOffset);
    expRes[ch] = v < 0 ? 0 : (v > 16383 ? 16383 : v);
    @(negedge clk);
    convDone = 1'b0;
  end

  // One packet reads all nine result pairs from the aux pair upward
  task automatic read_all();
    logic [7:0] hi, lo;
    host.frame_open();
    host.xfer({AUX_RESULT_HIGH, 1'b0}, rx);
    for (int c = 0; c < 9; c++) begin
      int k;
      k = c == 0 ? 8 : c - 1;
      host.xfer(8'h00, hi);
      host.xfer(8'h00, lo);
      check_byte("result high", 8'(expRes[k] >> 8), hi);
      check_byte("result low", 8'(expRes[k]), lo);
      if (c == 1) check_pins("data enable", 8'h01, {7'h0, hostOut.dataOe});
      if (c == 1) begin
        check_mv("cell mV", 16'(expRes[k] * 6250 / 16383), 16'({hi, lo} * 6250 / 16383));
      end
    end
    host.frame_close();
    repeat (6) @(negedge clk);
    check_pins("data enable", 8'h00, {7'h0, hostOut.dataOe});
  endtask

  // Start by pin or by control write, then compare every stored word
  task automatic scan(input int cnt, input logic aux, input bit pin);
    int n;
    n = (cnt == 0 || cnt == 7) ? 6 : cnt;
    for (int i = 0; i < n; i++) chq.push_back(i);
    chq.push_back(6);
    chq.push_back(7);
    chq.push_back(8);
    if (pin) host.pulse_conv();
    else begin
      host.frame_open();
      host.xfer({CONVERSION_CONTROL, 1'b1}, rx);
      host.xfer({3'h0, 1'b1, aux, 3'(cnt)}, rx);
      host.frame_close();
    end
    for (int t = 0; t < 5000 && chq.size() > 0; t++) @(negedge clk);
    repeat (20) @(negedge clk);
    check_pins("scan length", 8'h00, 8'(chq.size()));
    check_pins("aux source", {7'h0, aux}, {7'h0, auxSource});
    read_all();
    $display("scan of %0d cells done", n);
  endtask

  // Random pin patterns on the lower port and the upper returns
  task automatic relay_test();
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      hostSelect = 1'($random(seed));
      lowerIn = port_in_t'(4'($random(seed)) | 4'h4);
      upperIn = upper_in_t'(4'($random(seed)));
      localFault = 1'($random(seed));
      localAlert = 1'($random(seed));
      repeat (6) @(negedge clk);
      want = {upperIn.dataReturn, 1'b0, upperIn.ready, upperIn.fault | localFault,
        upperIn.alert | localAlert};
      check_pins("upward", {4'h0, hostSelect ? lowerIn : hostIn}, {4'h0, upOut});
      check_pins("selected down", {3'h0, want}, {3'h0, hostSelect ? lowerOut : hostOut});
      check_pins("idle down", 8'h00, {3'h0, hostSelect ? hostOut : lowerOut});
    end
    $display("relay test done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, well beyond the expected few hundred microseconds
  initial begin
    #900000;
    err_count++;
    final_report();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    check_pins("reset aux", 8'h00, {7'h0, auxSource});
    read_all();
    scan(6, 1'b0, 1'b1);
    for (int j = 0; j < 5; j++) scan(j + 3, 1'($random(seed)), 1'b0);
    host.frame_open();
    host.xfer(8'h80, rx);
    host.xfer(8'h00, rx);
    host.frame_close();
    check_byte("unmapped", 8'h00, rx);
    relay_test();
    final_report();
  end
endmodule
